// File: rtl/core_mem_pkg.sv
// Shared constants for the core memory cycle controller.
// Assumes a single 40 MHz clock; all bus pins are asynchronous to it.
package core_mem_pkg;
	// ==========================================================
	// Bus address fields
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int BANK_W = 4;
	localparam int BANK_HI = 17;
	localparam int BANK_LO = 14;
	localparam int ROW_W = 7;
	localparam int ROW_HI = 13;
	localparam int ROW_LO = 7;
	localparam int COL_W = 6;
	localparam int COL_HI = 6;
	localparam int COL_LO = 1;
	localparam int BYTE_SEL_BIT = 0;

	// ==========================================================
	// Cycle type codes on the two control lines
	localparam logic [1:0] CTL_READ_RESTORE = 2'h0;
	localparam logic [1:0] CTL_READ_PAUSE = 2'h1;
	localparam logic [1:0] CTL_WRITE_WORD = 2'h2;
	localparam logic [1:0] CTL_WRITE_BYTE = 2'h3;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int FULL_CYCLE_NS = 900;
	localparam int HALF_CYCLE_NS = 450;
	localparam int READ_ACCESS_NS = 400;
	localparam int WRITE_ACCEPT_NS = 200;
	localparam int CNT_W = 6;
	// Each phase is half the full cycle; exact multiple of the period
	localparam logic [CNT_W-1:0] HALF_CYCLES = CNT_W'(HALF_CYCLE_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FULL_CYCLES = CNT_W'(FULL_CYCLE_NS / CLK_PERIOD_NS);
	// Longest times round down
	localparam logic [CNT_W-1:0] ACCESS_MAX = CNT_W'(READ_ACCESS_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] ACCEPT_MAX = CNT_W'(WRITE_ACCEPT_NS / CLK_PERIOD_NS);
	// Sense strobe point inside the read phase
	localparam logic [CNT_W-1:0] STROBE_CYC = 6'h0A;

	// ==========================================================
	// Cycle sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WRITE = 4'h4,
		ST_DONE = 4'h8
	} cyc_state_t;
endpackage

// File: rtl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the group is sampled on clk and read only from q.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in, synchronised copy out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// ==========================================================
	// First stage feeds the second only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule

// File: rtl/core_cycle_ctrl.sv
// Cycle sequencer for a 16-bit core memory bank on an asynchronous bus.
// Assumes bus pins and sense amplifier outputs are asynchronous to clk.
//
// Function
// - Recognise and sequence four bus cycle types
// - Read 900 ns, pause 450, data by 400
// - Writes accept data by 200; 900/450 ns
// - Read-restore loads register, then writes back
// - Pause read skips write-back, sets flag
// - Word write clears by reading, then writes
// - Pause flag set: write skips clearing read
// - Byte write merges sensed and bus bytes
// - Byte write stores both halves together
// - Byte write after pause skips read
// - Address bit zero selects written byte
// - Latch full 18-bit address per cycle
// - Read and write drive, opposite polarity
// - Power fail inhibits all core drive
// - Bits 17..14 compared with bank number
// - Bits 13..1 select word; even low
`timescale 1ns/1ps
module core_cycle_ctrl
	import core_mem_pkg::*;
#(
	parameter logic [core_mem_pkg::BANK_W-1:0] BANK_NUM = 4'h0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus request side
	input wire logic [core_mem_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [1:0] bus_ctl,
	input wire logic bus_msyn,
	input wire logic bus_dc_lo_n,
	// Bus data and reply
	input wire logic [core_mem_pkg::DATA_W-1:0] bus_data_in,
	output logic [core_mem_pkg::DATA_W-1:0] bus_data_out,
	output logic bus_data_oe,
	output logic bus_ssyn_oe,
	// Core stack drive
	output logic [core_mem_pkg::ROW_W-1:0] core_row,
	output logic [core_mem_pkg::COL_W-1:0] core_col,
	output logic read_drv,
	output logic write_drv_n,
	output logic [core_mem_pkg::DATA_W-1:0] inhibit,
	output logic sense_strobe,
	input wire logic [core_mem_pkg::DATA_W-1:0] sense_bits
);
	import core_mem_pkg::*;

	localparam int SYNC_W = 2 + 2 + ADDR_W + 2 * DATA_W;

	// ==========================================================
	// Helpers
	function automatic logic is_write(input logic [1:0] c);
		return c[1];
	endfunction

	// Selected byte from new_w, the other byte from old_w
	function automatic logic [DATA_W-1:0] byte_merge(input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w, input logic hi_sel);
		return hi_sel ? {new_w[15:8], old_w[7:0]} : {old_w[15:8], new_w[7:0]};
	endfunction

	// ==========================================================
	// Pin synchronisation
	logic msyn_s;
	logic pwr_ok;
	logic [1:0] ctl_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic [DATA_W-1:0] sense_s;

	pin_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({bus_msyn, bus_dc_lo_n, bus_ctl, bus_addr, bus_data_in, sense_bits}),
		.q({msyn_s, pwr_ok, ctl_s, addr_s, data_s, sense_s})
	);

	// ==========================================================
	// State
	cyc_state_t state_reg;
	cyc_state_t state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [1:0] ctl_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] data_next;
	logic pause_reg;
	logic pause_next;
	logic ssyn_reg;
	logic ssyn_next;
	logic data_oe_reg;
	logic data_oe_next;

	// ==========================================================
	// Request decode
	wire in_idle = (state_reg == ST_IDLE);
	wire in_read = (state_reg == ST_READ);
	wire in_write = (state_reg == ST_WRITE);
	wire bank_hit = (addr_s[BANK_HI:BANK_LO] == BANK_NUM);
	// Other banks and power fail never start a cycle
	wire start_go = in_idle & msyn_s & ~ssyn_reg & bank_hit & pwr_ok;
	wire start_wr = start_go & is_write(ctl_s);
	wire phase_end = (cnt_reg == HALF_CYCLES - 6'h01);
	wire strobe = in_read & (cnt_reg == STROBE_CYC);
	wire rd_type = ~is_write(ctl_reg);
	wire read_ack = strobe & rd_type;

	// ==========================================================
	// Sequencer: read phase then write phase, each half a cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_go) begin
					// Write after a pause read goes straight to writing
					state_next = (is_write(ctl_s) && pause_reg) ? ST_WRITE : ST_READ;
				end
			end
			ST_READ: begin
				if (phase_end) begin
					// Pause read ends at the half cycle; others continue
					state_next = (ctl_reg == CTL_READ_PAUSE) ? ST_DONE : ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (phase_end) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				// Wait until the master has seen the reply and let go
				if (!ssyn_reg) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	assign cnt_next = (state_next != state_reg) ? '0 :
		((in_read | in_write) ? cnt_reg + 6'h01 : cnt_reg);

	// ==========================================================
	// Data register: bus data at acceptance, sense data at strobe
	always_comb begin
		data_next = data_reg;
		if (start_wr) begin
			if (ctl_s == CTL_WRITE_BYTE) begin
				data_next = byte_merge(data_reg, data_s, addr_s[BYTE_SEL_BIT]);
			end else begin
				data_next = data_s;
			end
		end else if (strobe) begin
			case (ctl_reg)
				CTL_READ_RESTORE: data_next = sense_s;
				CTL_READ_PAUSE: data_next = sense_s;
				// Keep the bus byte, take the other half from the cores
				CTL_WRITE_BYTE: data_next = byte_merge(sense_s, data_reg,
					addr_reg[BYTE_SEL_BIT]);
				default: data_next = data_reg; // Word write only clears
			endcase
		end
	end

	// Pause flag set by a pause read, dropped when the write finishes
	assign pause_next = (in_read & phase_end & (ctl_reg == CTL_READ_PAUSE)) ? 1'b1 :
		((in_write & phase_end) ? 1'b0 : pause_reg);

	// Reply held until the master drops its sync; set wins over clear
	assign ssyn_next = start_wr | read_ack | (ssyn_reg & msyn_s);
	assign data_oe_next = read_ack | (data_oe_reg & msyn_s);

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			addr_reg <= '0;
			ctl_reg <= CTL_READ_RESTORE;
			data_reg <= '0;
			pause_reg <= 1'b0;
			ssyn_reg <= 1'b0;
			data_oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			data_reg <= data_next;
			pause_reg <= pause_next;
			ssyn_reg <= ssyn_next;
			data_oe_reg <= data_oe_next;
			if (start_go) begin
				addr_reg <= addr_s;
				ctl_reg <= ctl_s;
			end
		end
	end

	// ==========================================================
	// Stack drive; power fail forces every driver off
	wire drive_rd = in_read & pwr_ok;
	wire drive_wr = in_write & pwr_ok;
	assign read_drv = drive_rd;
	assign write_drv_n = ~drive_wr;
	// Inhibit keeps a core at 0; both bytes written in one phase
	assign inhibit = drive_wr ? ~data_reg : '0;
	assign sense_strobe = strobe & pwr_ok;
	assign core_row = addr_reg[ROW_HI:ROW_LO];
	assign core_col = addr_reg[COL_HI:COL_LO];
	assign bus_data_out = data_reg;
	assign bus_data_oe = data_oe_reg;
	assign bus_ssyn_oe = ssyn_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_read_access: assert property (
		start_go && !is_write(ctl_s) |-> ##[1:16] (bus_data_oe && bus_ssyn_oe))
		else $error("read data late");
	chk_write_accept: assert property (
		start_wr |-> ##[1:8] bus_ssyn_oe)
		else $error("write data not accepted in time");
	chk_skip_read: assert property (
		start_wr && pause_reg |=> in_write && cnt_reg == 6'h00)
		else $error("paused write did not skip read phase");
	chk_full_read: assert property (
		start_wr && !pause_reg |=> (in_read && cnt_reg == 6'h00) ##17 (in_read && phase_end)
		##1 in_write)
		else $error("ordinary write missing clearing read");
	chk_pause_len: assert property (
		in_read && phase_end && ctl_reg == CTL_READ_PAUSE |=> state_reg == ST_DONE && pause_reg)
		else $error("pause read did not end at half cycle");
	chk_write_end: assert property (
		in_write && phase_end |=> state_reg == ST_DONE && !pause_reg)
		else $error("write phase end wrong");
	chk_drive_excl: assert property (
		!(read_drv && !write_drv_n))
		else $error("read and write drive together");
	chk_power_inhibit: assert property (
		!pwr_ok |-> !read_drv && write_drv_n && inhibit == '0 && !sense_strobe)
		else $error("core drive during power fail");
	chk_bank_ignore: assert property (
		in_idle && msyn_s && !bank_hit |=> in_idle && !bus_ssyn_oe)
		else $error("answered foreign bank");
	chk_restore_data: assert property (
		in_read && phase_end && ctl_reg == CTL_READ_RESTORE |=> (inhibit == ~data_reg || !pwr_ok)
		&& $stable(data_reg))
		else $error("restore does not write back register");
endmodule

// File: bench/core_bus_master.sv
// Bus master model: one request per call, reply collected.
// Assumes the bench owns clk and calls run from its sequence.
`timescale 1ns/1ps
module core_bus_master
	import core_mem_pkg::*;
(
	// Clock
	input wire logic clk,
	// Request pins
	output logic [core_mem_pkg::ADDR_W-1:0] bus_addr,
	output logic [1:0] bus_ctl,
	output logic bus_msyn,
	output logic [core_mem_pkg::DATA_W-1:0] bus_data_in,
	// Reply pins
	input wire logic [core_mem_pkg::DATA_W-1:0] bus_data_out,
	input wire logic bus_ssyn_oe
);
	// ==========================================================
	// Idle pins
	initial begin
		bus_addr = '0;
		bus_ctl = 2'h0;
		bus_msyn = 1'b0;
		bus_data_in = '0;
	end

	// Pins settle 3 cycles before msyn, outlasting the sync delay
	task automatic run(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
			output logic [15:0] q, output logic ok, output int lat);
		int n;
		ok = 1'b0;
		lat = 0;
		@(posedge clk);
		bus_addr <= a;
		bus_ctl <= c;
		bus_data_in <= d;
		repeat (3) @(posedge clk);
		bus_msyn <= 1'b1;
		// Reply sampled between edges, where it has settled
		for (n = 0; n < 30 && !ok; n++) begin
			@(negedge clk);
			lat++;
			ok = (bus_ssyn_oe === 1'b1);
		end
		q = bus_data_out;
		@(posedge clk);
		bus_msyn <= 1'b0;
		for (n = 0; n < 10 && bus_ssyn_oe !== 1'b0; n++) @(negedge clk);
		// A reply that never lets go counts as no reply
		if (bus_ssyn_oe !== 1'b0) ok = 1'b0;
		@(posedge clk);
		// Released lines show the inverse, not a stale value
		bus_addr <= ~a;
		bus_data_in <= ~d;
		// Busy time of 36 cycles is over before the next request
		repeat (40) @(posedge clk);
	endtask
endmodule

// File: bench/core_cycle_ctrl_tb.sv
// Testbench for the core cycle sequencer, with a small core stack.
// Assumes the bus master model and the bank number 4'h5.
`timescale 1ns/1ps
module core_cycle_ctrl_tb;
	import core_mem_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic dc_ok = 1'b1;
	logic [17:0] addr;
	logic [1:0] ctl;
	logic msyn, doe, soe, rdrv, wdrv_n, strobe;
	logic [15:0] din, dout, inh, sense;
	logic [6:0] row;
	logic [5:0] col;
	logic [15:0] mem [0:8191];
	int failures = 0;
	int comparisons = 0;
	int rd_cnt, wr_cnt, both, oe_cnt;
	localparam logic [17:0] A1 = {4'h5, 7'h12, 6'h21, 1'b0};
	localparam logic [17:0] A2 = {4'h5, 7'h6D, 6'h1E, 1'b0};

	always #12.5 clk = ~clk;

	core_cycle_ctrl #(.BANK_NUM(4'h5)) u_core_cycle_ctrl (.clk(clk), .rst_n(rst_n),
		.bus_addr(addr), .bus_ctl(ctl), .bus_msyn(msyn), .bus_dc_lo_n(dc_ok),
		.bus_data_in(din), .bus_data_out(dout), .bus_data_oe(doe), .bus_ssyn_oe(soe),
		.core_row(row), .core_col(col), .read_drv(rdrv), .write_drv_n(wdrv_n),
		.inhibit(inh), .sense_strobe(strobe), .sense_bits(sense));
	core_bus_master u_core_bus_master (.clk(clk), .bus_addr(addr), .bus_ctl(ctl),
		.bus_msyn(msyn), .bus_data_in(din), .bus_data_out(dout), .bus_ssyn_oe(soe));

	// ==========================================================
	// Core stack: strobe clears the word, write sets uninhibited bits
	assign sense = rdrv ? mem[{row, col}] : ~mem[{row, col}];
	initial for (int i = 0; i < 8192; i++) mem[i] = 16'h0000;
	// Sampled between edges, so no race with the edge that moves the drives
	always @(negedge clk) begin
		if (strobe === 1'b1) mem[{row, col}] <= 16'h0000;
		if (wdrv_n === 1'b0) mem[{row, col}] <= mem[{row, col}] | ~inh;
		rd_cnt += int'(rdrv === 1'b1);
		wr_cnt += int'(wdrv_n === 1'b0);
		both += int'(rdrv === 1'b1 && wdrv_n === 1'b0);
		oe_cnt += int'(doe === 1'b1);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// One accepted cycle, with phase lengths in cycles
	task automatic op(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
			input int rd, input int wr, output logic [15:0] q);
		logic ok;
		int lat;
		rd_cnt = 0;
		wr_cnt = 0;
		both = 0;
		oe_cnt = 0;
		u_core_bus_master.run(a, c, d, q, ok, lat);
		check(ok, 1, "no reply");
		if (ok !== 1'b1) print_verdict();
		check(lat <= (c[1] ? ACCEPT_MAX + 4 : ACCESS_MAX + 4), 1, "late reply");
		check(rd_cnt, rd, "read phase length");
		check(wr_cnt, wr, "write phase length");
		check(both, 0, "drives overlap");
		check(oe_cnt > 0, !c[1], "read data enable");
	endtask

	task automatic t_word();
		logic [15:0] q;
		op(A1, CTL_WRITE_WORD, 16'h1234, 18, 18, q);
		op(A2, CTL_WRITE_WORD, 16'hFEDC, 18, 18, q);
		op(A1, CTL_READ_RESTORE, 16'h0000, 18, 18, q);
		check(q, 16'h1234, "read data");
		op(A1, CTL_READ_RESTORE, 16'h0000, 18, 18, q);
		check(q, 16'h1234, "restored data");
		$display("t_word done");
	endtask

	task automatic t_pause();
		logic [15:0] q;
		op(A1, CTL_READ_PAUSE, 16'h0000, 18, 0, q);
		check(q, 16'h1234, "pause read data");
		op(A1, CTL_WRITE_WORD, 16'h5A5A, 0, 18, q);
		op(A1, CTL_READ_RESTORE, 16'h0000, 18, 18, q);
		check(q, 16'h5A5A, "write after pause data");
		op(A1, CTL_WRITE_WORD, 16'h0F0F, 18, 18, q);
		op(A1, CTL_READ_RESTORE, 16'h0000, 18, 18, q);
		check(q, 16'h0F0F, "write data");
		$display("t_pause done");
	endtask

	task automatic t_byte();
		logic [15:0] q;
		op(A1 | 18'h1, CTL_WRITE_BYTE, 16'hAB00, 18, 18, q);
		op(A1, CTL_WRITE_BYTE, 16'h00CD, 18, 18, q);
		op(A1, CTL_READ_PAUSE, 16'h0000, 18, 0, q);
		check(q, 16'hABCD, "byte merge");
		op(A1 | 18'h1, CTL_WRITE_BYTE, 16'h7700, 0, 18, q);
		op(A1, CTL_READ_RESTORE, 16'h0000, 18, 18, q);
		check(q, 16'h77CD, "byte after pause");
		$display("t_byte done");
	endtask

	task automatic t_refuse();
		logic [15:0] q;
		logic ok;
		int lat;
		rd_cnt = 0;
		wr_cnt = 0;
		u_core_bus_master.run({4'h6, A1[13:0]}, CTL_READ_RESTORE, 16'h0000, q, ok, lat);
		check({ok, 31'(rd_cnt + wr_cnt)}, 0, "other bank answered");
		dc_ok <= 1'b0;
		u_core_bus_master.run(A2, CTL_WRITE_WORD, 16'h0000, q, ok, lat);
		check({ok, 31'(rd_cnt + wr_cnt)}, 0, "drive in power fail");
		dc_ok <= 1'b1;
		repeat (4) @(posedge clk);
		op(A2, CTL_READ_RESTORE, 16'h0000, 18, 18, q);
		check(q, 16'hFEDC, "word kept");
		$display("t_refuse done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_word();
		t_pause();
		t_byte();
		t_refuse();
		print_verdict();
	end
endmodule
